/* File: design/modem_status_baud.sv */
// Purpose: Modem status register with change flags and a 16x baud divider
// Assumes: Handshake pins are asynchronous; AHB-Lite slave with no wait states
// Notes: Status reads take effect at the end of the data phase
`timescale 1ns/1ps
module modem_status_baud #(
   parameter int ADDR_W = 8
) (
   input wire logic CORE_CLK,
   input wire logic NRST,
   input wire logic HSEL,
   input wire logic [ADDR_W-1:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic CTS_N,
   input wire logic DSR_N,
   input wire logic RI_N,
   input wire logic DCD_N,
   output logic RTS_N,
   output logic DTR_N,
   output logic BAUD16_TICK,
   output logic MSI_IRQ
);
   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   logic [4:0] modem_control_reg;
   logic msi_enable;
   logic [7:0] div_low;
   logic [7:0] divisor_high_byte;
   logic [15:0] cnt;
   logic [3:0] lvl;
   logic [3:0] lvl_q;
   logic [3:0] ev;
   logic [3:0] delta;
   logic [3:0] held;
   logic [3:0] next_delta;
   logic [15:0] next_div;
   logic rd_start;
   logic rd_busy;
   logic acc;
   logic wr_pend;
   logic [ADDR_W-1:0] wr_addr;
   logic loopback_select;
   logic div_wr;
   logic [7:0] rd_mux;

   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign acc = HSEL && HTRANS[1] && HREADY;
   assign rd_start = acc && !HWRITE && (HADDR == ADDR_W'(modem_status_pkg::MODEM_STATUS_OFS));
   assign loopback_select = modem_control_reg[modem_status_pkg::LOOP_BIT];

   // Pin order in vectors: 0 clear-to-send, 1 ready, 2 ring, 3 carrier
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         pin_s1 <= 4'hf;
         pin_s2 <= 4'hf;
      end else begin
         pin_s1 <= {DCD_N, RI_N, DSR_N, CTS_N};
         pin_s2 <= pin_s1;
      end
   end

   always_comb begin
      if (loopback_select) begin
         lvl = {modem_control_reg[3], modem_control_reg[2],
                modem_control_reg[0], modem_control_reg[1]};
      end else begin
         lvl = ~pin_s2;
      end
   end

   // Ring flag takes only the trailing edge: level indicator falling from one to zero
   assign ev[0] = lvl[0] ^ lvl_q[0];
   assign ev[1] = lvl[1] ^ lvl_q[1];
   assign ev[2] = lvl_q[2] & ~lvl[2];
   assign ev[3] = lvl[3] ^ lvl_q[3];

   // Events in the address phase of a status read wait in held until the read ends
   always_comb begin
      if (rd_busy) begin
         next_delta = (held | ev) & ~delta;
      end else if (rd_start) begin
         next_delta = delta;
      end else begin
         next_delta = delta | ev;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         lvl_q <= 4'h0;
         delta <= 4'h0;
         held <= 4'h0;
         rd_busy <= 1'b0;
      end else begin
         lvl_q <= lvl;
         delta <= next_delta;
         held <= (rd_start && !rd_busy) ? ev : 4'h0;
         rd_busy <= rd_start;
      end
   end

   // Registered request, taken from next_delta so it changes in the same cycle as the flags
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         MSI_IRQ <= 1'b0;
      end else begin
         MSI_IRQ <= msi_enable && (next_delta != 4'h0);
      end
   end

   // Write data arrives one cycle after the address phase
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         wr_pend <= 1'b0;
         wr_addr <= '0;
      end else begin
         wr_pend <= acc && HWRITE;
         wr_addr <= HADDR;
      end
   end

   // Either divisor byte write restarts the count
   assign div_wr = wr_pend && (wr_addr == ADDR_W'(modem_status_pkg::DIV_LOW_OFS) ||
                               wr_addr == ADDR_W'(modem_status_pkg::DIV_HIGH_OFS));

   always_comb begin
      next_div = {divisor_high_byte, div_low};
      if (wr_pend && wr_addr == ADDR_W'(modem_status_pkg::DIV_LOW_OFS)) begin
         next_div[7:0] = HWDATA[7:0];
      end
      if (wr_pend && wr_addr == ADDR_W'(modem_status_pkg::DIV_HIGH_OFS)) begin
         next_div[15:8] = HWDATA[7:0];
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         modem_control_reg <= modem_status_pkg::MCR_RESET;
         msi_enable <= 1'b0;
         div_low <= modem_status_pkg::DIV_RESET[7:0];
         divisor_high_byte <= modem_status_pkg::DIV_RESET[15:8];
      end else if (wr_pend) begin
         if (wr_addr == ADDR_W'(modem_status_pkg::MODEM_CTRL_OFS)) begin
            modem_control_reg <= HWDATA[4:0];
         end
         if (wr_addr == ADDR_W'(modem_status_pkg::INT_ENABLE_OFS)) begin
            msi_enable <= HWDATA[modem_status_pkg::MSI_EN_BIT];
         end
         div_low <= next_div[7:0];
         divisor_high_byte <= next_div[15:8];
      end
   end

   // Outputs go inactive high in loopback
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         RTS_N <= 1'b1;
         DTR_N <= 1'b1;
      end else begin
         RTS_N <= loopback_select || !modem_control_reg[1];
         DTR_N <= loopback_select || !modem_control_reg[0];
      end
   end

   // Tick every divisor cycles gives the 16x sampling clock; zero stops it
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         cnt <= modem_status_pkg::DIV_RESET;
         BAUD16_TICK <= 1'b0;
      end else if (div_wr) begin
         cnt <= next_div;
         BAUD16_TICK <= 1'b0;
      end else if (cnt <= 16'h0001 && next_div != 16'h0000) begin
         cnt <= next_div;
         BAUD16_TICK <= 1'b1;
      end else begin
         cnt <= (cnt == 16'h0000) ? 16'h0000 : cnt - 16'h0001;
         BAUD16_TICK <= 1'b0;
      end
   end

   // Status read returns the flags as they stand before its own events
   always_comb begin
      rd_mux = 8'h00;
      case (HADDR)
         ADDR_W'(modem_status_pkg::DIV_LOW_OFS): rd_mux = div_low;
         ADDR_W'(modem_status_pkg::DIV_HIGH_OFS): rd_mux = divisor_high_byte;
         ADDR_W'(modem_status_pkg::MODEM_CTRL_OFS): rd_mux = {3'h0, modem_control_reg};
         ADDR_W'(modem_status_pkg::INT_ENABLE_OFS): rd_mux = {4'h0, msi_enable, 3'h0};
         ADDR_W'(modem_status_pkg::MODEM_STATUS_OFS): rd_mux = {lvl_q, next_delta};
         default: rd_mux = 8'h00;
      endcase
   end

   // Captured in the address phase; stands until the next read
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         HRDATA <= 32'h0000_0000;
      end else if (acc && !HWRITE) begin
         HRDATA <= {24'h00_0000, rd_mux};
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);

   chk_delta_read_clear: assert property (
      rd_busy && (held | ev) == 4'h0 |=> delta == 4'h0)
      else $error("change flags not cleared by status read");
   chk_level_from_pins: assert property (
      !loopback_select && !$past(loopback_select) && !$past(loopback_select, 2)
      |-> ##1 lvl_q == ~{$past(DCD_N, 3), $past(RI_N, 3), $past(DSR_N, 3), $past(CTS_N, 3)})
      else $error("level bits do not follow synchronised pins");
   chk_loop_levels: assert property (
      loopback_select |=> lvl_q == {$past(modem_control_reg[3]), $past(modem_control_reg[2]),
                                    $past(modem_control_reg[0]), $past(modem_control_reg[1])})
      else $error("loopback level bits wrong");
   chk_ring_rise_ignored: assert property (
      $rose(lvl_q[2]) && !$past(delta[2]) && !$past(rd_busy) |-> !delta[2])
      else $error("ring flag set by wrong edge");
   chk_ring_fall_sets: assert property (
      $fell(lvl_q[2]) && !$past(rd_busy) && !$past(rd_start) |-> delta[2])
      else $error("ring flag missed trailing edge");
   chk_irq_follows: assert property (
      msi_enable && delta != 4'h0 && !rd_busy && !wr_pend |=> MSI_IRQ)
      else $error("modem status interrupt missing");
   chk_hold_in_read: assert property (
      rd_start && !rd_busy |=> delta == $past(delta))
      else $error("flag changed during status read");
   chk_recur_clears: assert property (
      rd_busy && (delta & (held | ev)) != 4'h0
      |=> (delta & $past(delta) & ($past(held) | $past(ev))) == 4'h0)
      else $error("recurring flag not cleared at read end");
   chk_read_levels: assert property (
      rd_start |=> HRDATA[7:4] == $past(lvl_q))
      else $error("status read shows wrong levels");
   chk_div_reload: assert property (
      div_wr |=> cnt == $past(next_div) && !BAUD16_TICK)
      else $error("divisor write did not reload counter");
   chk_baud_period: assert property (
      BAUD16_TICK && !div_wr && cnt > 16'h0001 |=> !BAUD16_TICK)
      else $error("baud tick too early");

   // Flag, interrupt, control and divider invariants
   chk_irq_disabled: assert property (
      !msi_enable |=> !MSI_IRQ)
      else $error("modem status interrupt raised while disabled");
   chk_flag_hold_idle: assert property (
      !rd_start && !rd_busy && ev == 4'h0 |=> delta == $past(delta))
      else $error("change flags moved without an event");
   chk_flag_sets: assert property (
      !rd_start && !rd_busy && ev != 4'h0 |=> (delta & $past(ev)) == $past(ev))
      else $error("change flag not latched on input change");
   chk_loop_outputs_idle: assert property (
      loopback_select |=> RTS_N && DTR_N)
      else $error("modem control outputs active in loopback");
   chk_dtr_follows: assert property (
      !loopback_select |=> DTR_N == !$past(modem_control_reg[0]))
      else $error("terminal-ready output does not follow its control bit");
   chk_ctrl_write: assert property (
      wr_pend && wr_addr == ADDR_W'(modem_status_pkg::MODEM_CTRL_OFS)
      |=> modem_control_reg == $past(HWDATA[4:0]))
      else $error("modem control write lost");
   chk_div_one_ticks: assert property (
      next_div == 16'h0001 && !div_wr |=> BAUD16_TICK)
      else $error("divisor one does not tick every cycle");
   chk_div_zero_idle: assert property (
      next_div == 16'h0000 && !div_wr |=> !BAUD16_TICK)
      else $error("generator ticks with divisor zero");

   cov_read_with_event: cover property (rd_busy && ev != 4'h0);
   cov_recur_in_read: cover property (rd_busy && (delta & (held | ev)) != 4'h0);
   cov_baud_tick: cover property (BAUD16_TICK ##[1:20] BAUD16_TICK);
   cov_irq_rise: cover property ($rose(MSI_IRQ));
   cov_loop_read: cover property (loopback_select && rd_start);
endmodule

/* File: design/modem_status_pkg.sv */
// Purpose: Shared constants for the modem status and baud generator block
// Assumes: AHB-Lite register bus, 32-bit data, one word per register
// Notes: Offsets are byte addresses
package modem_status_pkg;
   localparam logic [7:0] DIV_LOW_OFS = 8'h00;
   localparam logic [7:0] DIV_HIGH_OFS = 8'h04;
   localparam logic [7:0] MODEM_CTRL_OFS = 8'h08;
   localparam logic [7:0] INT_ENABLE_OFS = 8'h0c;
   localparam logic [7:0] MODEM_STATUS_OFS = 8'h10;
   localparam int LOOP_BIT = 4;
   localparam int MSI_EN_BIT = 3;
   localparam int LEVEL_LSB = 4;
   localparam logic [4:0] MCR_RESET = 5'h00;
   localparam logic [15:0] DIV_RESET = 16'h0000;
   localparam int SYNC_STAGES = 2;
endpackage

/* File: test/modem_partner.sv */
// Purpose: Modem side model driving the four handshake inputs
// Assumes: Levels requested by the bench, launched on the clock edge
// Notes: Pins idle high, i.e. all handshakes inactive
`timescale 1ns/1ps
module modem_partner (
   input wire logic clk,
   input wire logic [3:0] want_n,
   output logic cts_n,
   output logic dsr_n,
   output logic ri_n,
   output logic dcd_n
);
   always_ff @(posedge clk) begin
      {dcd_n, ri_n, dsr_n, cts_n} <= want_n;
   end
endmodule

/* File: test/uart_modem_status_and_baud_gen_tb_top.sv */
// Purpose: Self-checking bench for modem status and baud divider
// Assumes: Single AHB-Lite slave, hready taken from hreadyout
// Notes: Pin vectors are ordered carrier, ring, ready, clear-to-send
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_total++; \
$display("BAD %s exp %h got %h", nm, ex, got); end end
module uart_modem_status_and_baud_gen_tb_top;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, rts_n, dtr_n, tick, irq, cts_n, dsr_n, ri_n, dcd_n;
   logic [3:0] want_n = 4'hf;
   logic [3:0] pin_n = 4'hf;
   logic [3:0] src_n = 4'hf;
   logic [3:0] nsrc;
   logic [7:0] e;
   logic [31:0] rd;
   logic [4:0] c;
   int err_total = 0;
   int num_checks = 0;
   int cyc = 0;
   int n, div;
   initial forever #50 clk = ~clk;
   modem_status_baud DUT (.CORE_CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .CTS_N(cts_n), .DSR_N(dsr_n),
      .RI_N(ri_n), .DCD_N(dcd_n), .RTS_N(rts_n), .DTR_N(dtr_n), .BAUD16_TICK(tick),
      .MSI_IRQ(irq));
   modem_partner modem (.clk(clk), .want_n(want_n), .cts_n(cts_n), .dsr_n(dsr_n),
      .ri_n(ri_n), .dcd_n(dcd_n));
   // Status expected after a move of the active-low sources from o to w
   function automatic logic [7:0] exp_st(input logic [3:0] o, input logic [3:0] w);
      return {~w, o[3] ^ w[3], ~o[2] & w[2], o[1] ^ w[1], o[0] ^ w[0]};
   endfunction
   function automatic logic [3:0] loop_n(input logic [4:0] k);
      return ~{k[3], k[2], k[0], k[1]};
   endfunction
   task wrap_up;
      if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic ticks(output int k);
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (tick !== 1'b1 && k < 70000);
   endtask
   // Settle, then read status twice: flags, then levels only
   task automatic st_check;
      repeat (6) @(posedge clk);
      e = exp_st(src_n, nsrc);
      `CHK("irq", |e[3:0], irq)
      bus(1'b0, modem_status_pkg::MODEM_STATUS_OFS, 32'h0, rd);
      `CHK("status", {24'h0, e}, rd)
      bus(1'b0, modem_status_pkg::MODEM_STATUS_OFS, 32'h0, rd);
      `CHK("status reread", {24'h0, e[7:4], 4'h0}, rd)
      `CHK("irq cleared", 1'b0, irq)
      src_n = nsrc;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         wrap_up;
      end
   end
   initial begin
      rd = $urandom(88);
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, 8'(i * 4), 32'h0, rd);
         `CHK("reset reg", 32'h0, rd)
      end
      `CHK("idle outputs", 3'b110, {rts_n, dtr_n, hresp})
      bus(1'b1, modem_status_pkg::INT_ENABLE_OFS, 32'h8, rd);
      for (int i = 0; i < 12; i++) begin
         nsrc = (i == 0) ? 4'hb : (i == 1) ? 4'hf : 4'($urandom);
         want_n <= nsrc;
         pin_n = nsrc;
         st_check;
      end
      // Events inside a status read: a set flag that recurs clears, a new one sets
      nsrc = src_n ^ 4'h1;
      want_n <= nsrc;
      repeat (6) @(posedge clk);
      e = exp_st(src_n, nsrc);
      src_n = nsrc;
      nsrc = src_n ^ 4'h3;
      want_n <= nsrc;
      repeat (2) @(posedge clk);
      bus(1'b0, modem_status_pkg::MODEM_STATUS_OFS, 32'h0, rd);
      `CHK("status in read", {24'h0, e}, rd)
      bus(1'b0, modem_status_pkg::MODEM_STATUS_OFS, 32'h0, rd);
      `CHK("recurring flag", {24'h0, ~nsrc, 4'h2}, rd)
      bus(1'b0, modem_status_pkg::MODEM_STATUS_OFS, 32'h0, rd);
      `CHK("flags after read", {24'h0, ~nsrc, 4'h0}, rd)
      `CHK("irq after read", 1'b0, irq)
      src_n = nsrc;
      pin_n = nsrc;
      for (int i = 0; i < 7; i++) begin
         c = {i < 6, 4'($urandom)};
         nsrc = (i < 6) ? loop_n(c) : pin_n;
         bus(1'b1, modem_status_pkg::MODEM_CTRL_OFS, {27'h0, c}, rd);
         if (i < 6) begin
            pin_n = 4'($urandom);
            want_n <= pin_n;
         end
         st_check;
         `CHK("rts dtr", (i < 6) ? 2'b11 : ~{c[1], c[0]}, {rts_n, dtr_n})
      end
      for (int i = 0; i < 3; i++) begin
         div = (i == 0) ? 1 : (i == 1) ? 2 + $urandom % 39 : 16'h0103;
         bus(1'b1, modem_status_pkg::DIV_HIGH_OFS, 32'(div[15:8]), rd);
         bus(1'b1, modem_status_pkg::DIV_LOW_OFS, 32'(div[7:0]), rd);
         ticks(n);
         // Counted from the write's final edge, so one more than the divisor
         `CHK("first tick", div + 1, n)
         ticks(n);
         `CHK("tick period", div, n)
         bus(1'b0, modem_status_pkg::DIV_HIGH_OFS, 32'h0, rd);
         n = rd << 8;
         bus(1'b0, modem_status_pkg::DIV_LOW_OFS, 32'h0, rd);
         `CHK("divisor", div, n | rd)
      end
      wrap_up;
   end
endmodule
